// File: pkg/meox_pkg.sv
package meox_pkg;

  localparam int          PC_W        = 11;
  localparam int          DATA_W      = 8;
  localparam int          FREG_W      = 7;
  localparam int          CP_W        = 4;
  localparam int          SP_W        = 3;
  localparam int          STACK_DEPTH = 8;

  localparam logic [10:0] RESET_PC    = 11'h000;
  localparam logic [10:0] SWI_VECTOR  = 11'h001;
  localparam logic [7:0]  RESET_ACC   = 8'h00;
  localparam logic [2:0]  RESET_SP    = 3'h0;
  localparam logic [3:0]  CP_LOW      = 4'h5;
  localparam logic [3:0]  CP_HIGH     = 4'hf;

  typedef enum logic [3:0] {
    OR_IMMEDIATE_OP       = 4'h0,
    OR_FILE_REG_OP        = 4'h1,
    STORE_CTRL_PAGE_OP    = 4'h2,
    LOAD_CTRL_PAGE_OP     = 4'h3,
    LONG_BRANCH_OP        = 4'h4,
    LONG_CALL_OP          = 4'h5,
    ACC_TO_FILE_REG_OP    = 4'h6,
    RETURN_IRQ_ENABLE_OP  = 4'h7,
    SOFT_IRQ_OP           = 4'h8
  } meox_op_type;

  // one-hot: three-cycle ops pass through cyc3 then cyc2
  typedef enum logic [2:0] {
    ST_READY = 3'b001,
    ST_CYC2  = 3'b010,
    ST_CYC3  = 3'b100
  } meox_state_type;

  typedef struct packed {
    meox_op_type  op;
    logic [7:0]   literal;
    logic [10:0]  target;
    logic [6:0]   freg;
    logic         dest;
    logic [3:0]   cp_sel;
  } meox_instr_type;

  typedef struct packed {
    logic         we;
    logic [6:0]   addr;
    logic [7:0]   data;
  } meox_freg_wr_type;

  typedef struct packed {
    logic         we;
    logic [3:0]   addr;
    logic [7:0]   data;
  } meox_cp_wr_type;

endpackage

// File: core/meox_exec_core.sv
`timescale 1ns/10ps
// What this block does
// - software interrupt pushes next address, jumps to 0x001, takes 3 cycles
// - or-immediate ors accumulator with literal, updates zero flag, one cycle
// - or-file-register result goes to accumulator (d=0) or register (d=1)
// - store-control-page copies accumulator into control register 5..15, one cycle
// - load-control-page copies control register 5..15 into accumulator, one cycle
// - long branch loads 11-bit target, stack untouched, two cycles
// - long call pushes own address plus one, loads target, two cycles
// - accumulator-to-file-register writes register, no flag change, one cycle
// - return-from-interrupt pops stack into pc, sets irq enable, two cycles
module meox_exec_core
  import meox_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             instr_valid_i,
  input  wire meox_instr_type   instr_i,
  input  wire logic [7:0]       freg_rdata_i,
  input  wire logic [7:0]       cp_rdata_i,
  output logic                  ready_o,
  output logic                  done_o,
  output logic [10:0]           pc_o,
  output logic [7:0]            acc_o,
  output logic                  zero_o,
  output logic                  gie_o,
  output logic [2:0]            sp_o,
  output meox_freg_wr_type      freg_wr_o,
  output meox_cp_wr_type        cp_wr_o
);

  function automatic logic cp_in_range(input logic [3:0] sel);
    cp_in_range = (sel >= CP_LOW) && (sel <= CP_HIGH);
  endfunction

  meox_state_type   state;
  meox_state_type   next_state;
  logic [10:0]      next_pc;
  logic [7:0]       next_acc;
  logic             next_zero;
  logic             next_gie;
  logic [2:0]       next_sp;
  logic             next_ready;
  logic             next_done;
  meox_freg_wr_type next_freg_wr;
  meox_cp_wr_type   next_cp_wr;
  logic             push_en;
  logic [10:0]      push_data;
  logic [10:0]      stack [STACK_DEPTH];
  logic [10:0]      top_of_stack;
  logic             accept;
  logic [7:0]       or_result;

  assign accept       = instr_valid_i && (state == ST_READY);
  assign top_of_stack = stack[sp_o - 3'h1];

  always_comb begin
    next_state   = state;
    next_pc      = pc_o;
    next_acc     = acc_o;
    next_zero    = zero_o;
    next_gie     = gie_o;
    next_sp      = sp_o;
    next_done    = 1'b0;
    next_freg_wr = '0;
    next_cp_wr   = '0;
    push_en      = 1'b0;
    push_data    = pc_o + 11'h001;
    or_result    = 8'h00;
    unique case (state)
      ST_READY: begin
        if (instr_valid_i) begin
          next_pc   = pc_o + 11'h001;
          next_done = 1'b1;
          unique case (instr_i.op)
            OR_IMMEDIATE_OP: begin
              or_result = acc_o | instr_i.literal;
              next_acc  = or_result;
              next_zero = (or_result == 8'h00);
            end
            OR_FILE_REG_OP: begin
              or_result = acc_o | freg_rdata_i;
              if (instr_i.dest) begin
                next_freg_wr = '{we: 1'b1, addr: instr_i.freg, data: or_result};
              end else begin
                next_acc = or_result;
              end
            end
            STORE_CTRL_PAGE_OP: begin
              // selectors outside 5..15 are dropped rather than aliased
              if (cp_in_range(instr_i.cp_sel)) begin
                next_cp_wr = '{we: 1'b1, addr: instr_i.cp_sel, data: acc_o};
              end
            end
            LOAD_CTRL_PAGE_OP: begin
              if (cp_in_range(instr_i.cp_sel)) begin
                next_acc = cp_rdata_i;
              end
            end
            LONG_BRANCH_OP: begin
              next_pc    = instr_i.target;
              next_done  = 1'b0;
              next_state = ST_CYC2;
            end
            LONG_CALL_OP: begin
              push_en    = 1'b1;
              next_sp    = sp_o + 3'h1;
              next_pc    = instr_i.target;
              next_done  = 1'b0;
              next_state = ST_CYC2;
            end
            ACC_TO_FILE_REG_OP: begin
              next_freg_wr = '{we: 1'b1, addr: instr_i.freg, data: acc_o};
            end
            RETURN_IRQ_ENABLE_OP: begin
              next_pc    = top_of_stack;
              next_sp    = sp_o - 3'h1;
              next_gie   = 1'b1;
              next_done  = 1'b0;
              next_state = ST_CYC2;
            end
            SOFT_IRQ_OP: begin
              push_en    = 1'b1;
              next_sp    = sp_o + 3'h1;
              next_pc    = SWI_VECTOR;
              next_done  = 1'b0;
              next_state = ST_CYC3;
            end
            default: begin
              next_pc   = pc_o;
              next_done = 1'b0;
            end
          endcase
        end
      end
      ST_CYC3: begin
        next_state = ST_CYC2;
      end
      ST_CYC2: begin
        next_state = ST_READY;
        next_done  = 1'b1;
      end
    endcase
    next_ready = (next_state == ST_READY);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= ST_READY;
      pc_o      <= RESET_PC;
      acc_o     <= RESET_ACC;
      zero_o    <= 1'b0;
      gie_o     <= 1'b0;
      sp_o      <= RESET_SP;
      ready_o   <= 1'b1;
      done_o    <= 1'b0;
      freg_wr_o <= '0;
      cp_wr_o   <= '0;
    end else begin
      state     <= next_state;
      pc_o      <= next_pc;
      acc_o     <= next_acc;
      zero_o    <= next_zero;
      gie_o     <= next_gie;
      sp_o      <= next_sp;
      ready_o   <= next_ready;
      done_o    <= next_done;
      freg_wr_o <= next_freg_wr;
      cp_wr_o   <= next_cp_wr;
    end
  end

  // stack is storage only, no reset needed; overflow wraps silently
  always_ff @(posedge clk_i) begin
    if (push_en) begin
      stack[sp_o] <= push_data;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence two_cycle_tail;
    (!ready_o && !done_o) ##1 (ready_o && done_o);
  endsequence

  sequence three_cycle_tail;
    (!ready_o && !done_o) ##1 two_cycle_tail;
  endsequence

  swi_jump_a: assert property (accept && instr_i.op == SOFT_IRQ_OP |=>
    pc_o == SWI_VECTOR && sp_o == $past(sp_o) + 3'h1 && top_of_stack == $past(pc_o) + 11'h001
    ##0 three_cycle_tail)
    else $error("software interrupt push or timing wrong");

  or_imm_a: assert property (accept && instr_i.op == OR_IMMEDIATE_OP |=>
    acc_o == ($past(acc_o) | $past(instr_i.literal)) && zero_o == (acc_o == 8'h00) && ready_o && done_o)
    else $error("or immediate result wrong");

  or_freg_a: assert property (accept && instr_i.op == OR_FILE_REG_OP |=>
    ($past(instr_i.dest) ? (freg_wr_o.we && freg_wr_o.data == ($past(acc_o) | $past(freg_rdata_i))
      && freg_wr_o.addr == $past(instr_i.freg) && $stable(acc_o))
     : (!freg_wr_o.we && acc_o == ($past(acc_o) | $past(freg_rdata_i)))))
    else $error("or file register destination wrong");

  // a dropped selector leaves the whole strobe word cleared, so data is judged only when written
  cp_store_a: assert property (accept && instr_i.op == STORE_CTRL_PAGE_OP |=>
    cp_wr_o.we == cp_in_range($past(instr_i.cp_sel)) && ready_o
    && (!cp_wr_o.we || (cp_wr_o.data == $past(acc_o) && cp_wr_o.addr == $past(instr_i.cp_sel))))
    else $error("control page store wrong");

  cp_load_a: assert property (accept && instr_i.op == LOAD_CTRL_PAGE_OP
    && cp_in_range(instr_i.cp_sel) |=> acc_o == $past(cp_rdata_i) && !cp_wr_o.we)
    else $error("control page load wrong");

  long_branch_a: assert property (accept && instr_i.op == LONG_BRANCH_OP |=>
    pc_o == $past(instr_i.target) && $stable(sp_o) ##0 two_cycle_tail)
    else $error("long branch wrong");

  long_call_a: assert property (accept && instr_i.op == LONG_CALL_OP |=>
    pc_o == $past(instr_i.target) && top_of_stack == $past(pc_o) + 11'h001 ##0 two_cycle_tail)
    else $error("long call wrong");

  acc_to_freg_a: assert property (accept && instr_i.op == ACC_TO_FILE_REG_OP |=>
    freg_wr_o.we && freg_wr_o.data == $past(acc_o) && freg_wr_o.addr == $past(instr_i.freg)
    && $stable(zero_o) && ready_o)
    else $error("accumulator store wrong");

  irq_return_a: assert property (accept && instr_i.op == RETURN_IRQ_ENABLE_OP |=>
    pc_o == $past(top_of_stack) && gie_o && sp_o == $past(sp_o) - 3'h1 ##0 two_cycle_tail)
    else $error("interrupt return wrong");

  push_pop_a: assert property (accept && instr_i.op == LONG_CALL_OP
    ##2 (accept && instr_i.op == RETURN_IRQ_ENABLE_OP) |=> pc_o == $past(pc_o, 3) + 11'h001)
    else $error("return address lost");

endmodule

// File: verif/meox_mem_model.sv
`timescale 1ns/10ps
module meox_mem_model
  import meox_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic [6:0]       freg_addr_i,
  input  wire logic [3:0]       cp_addr_i,
  input  wire meox_freg_wr_type freg_wr_i,
  input  wire meox_cp_wr_type   cp_wr_i,
  output logic [7:0]            freg_rdata_o,
  output logic [7:0]            cp_rdata_o
);
  logic [7:0] freg [128];
  logic [7:0] cp   [16];
  // distinct contents so a wrong address shows
  initial begin
    for (int i = 0; i < 128; i++) freg[i] = 8'hff ^ 8'(i);
    for (int i = 0; i < 16; i++) cp[i] = 8'h30 + 8'(i);
  end
  assign freg_rdata_o = freg[freg_addr_i];
  assign cp_rdata_o   = cp[cp_addr_i];
  always @(posedge clk_i) begin
    if (freg_wr_i.we) freg[freg_wr_i.addr] <= freg_wr_i.data;
    if (cp_wr_i.we) cp[cp_wr_i.addr] <= cp_wr_i.data;
  end
endmodule

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench
  import meox_pkg::*;
;
  logic             clk = 1'b0;
  logic             rst_i = 1'b1;
  logic             instr_valid_i = 1'b0;
  meox_instr_type   instr = '0;
  logic             ready_o, done_o, zero_o, gie_o, z;
  logic [10:0]      pc_o;
  logic [10:0]      pcx = 11'h000;
  logic [10:0]      stk[$];
  logic [7:0]       acc_o, freg_rd, cp_rd;
  logic [2:0]       sp_o;
  meox_freg_wr_type freg_wr_o;
  meox_cp_wr_type   cp_wr_o;
  int               err_total = 0;
  int               checks = 0;
  int               cyc = 0;

  always #4 clk = ~clk;

  meox_exec_core meox_exec_core_inst (.clk_i(clk), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr), .freg_rdata_i(freg_rd), .cp_rdata_i(cp_rd), .ready_o(ready_o), .done_o(done_o),
    .pc_o(pc_o), .acc_o(acc_o), .zero_o(zero_o), .gie_o(gie_o), .sp_o(sp_o), .freg_wr_o(freg_wr_o),
    .cp_wr_o(cp_wr_o));
  meox_mem_model meox_mem_model_inst (.clk_i(clk), .freg_addr_i(instr.freg), .cp_addr_i(instr.cp_sel),
    .freg_wr_i(freg_wr_o), .cp_wr_i(cp_wr_o), .freg_rdata_o(freg_rd), .cp_rdata_o(cp_rd));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // hang guard: the whole run needs about 50 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one instruction; judges cycle count, busy flag, pc and stack depth
  // valid stays up between calls: back-to-back offers never toggle it twice in one step,
  // and the core ignores it while busy; callers must not let an edge pass between calls
  task automatic exec(input meox_op_type op, input logic [10:0] arg, input int cyc_exp);
    int n;
    n = 1;
    instr = '{op: op, literal: arg[7:0], target: arg, freg: arg[6:0], dest: arg[7], cp_sel: arg[3:0]};
    instr_valid_i = 1'b1;
    @(posedge clk);
    #1;
    if (cyc_exp > 1) chk("busy", 16'h0000, 16'(ready_o));
    while (done_o !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    case (op)
      LONG_BRANCH_OP: pcx = arg;
      LONG_CALL_OP: begin
        stk.push_back(pcx + 11'h001);
        pcx = arg;
      end
      SOFT_IRQ_OP: begin
        stk.push_back(pcx + 11'h001);
        pcx = SWI_VECTOR;
      end
      RETURN_IRQ_ENABLE_OP: pcx = stk.pop_back();
      default: pcx = pcx + 11'h001;
    endcase
    chk("cycles", 16'(cyc_exp), 16'(n));
    chk("ready", 16'h0001, 16'(ready_o));
    chk("pc", 16'(pcx), 16'(pc_o));
    chk("sp", 16'(stk.size()), 16'(sp_o));
  endtask

  task automatic t_or_imm();
    exec(OR_IMMEDIATE_OP, 11'h000, 1);
    chk("zero_acc", 16'h0100, 16'({zero_o, acc_o}));
    exec(OR_IMMEDIATE_OP, 11'h050, 1);
    chk("zero_acc", 16'h0050, 16'({zero_o, acc_o}));
    exec(OR_IMMEDIATE_OP, 11'h0aa, 1);
    chk("zero_acc", 16'h00fa, 16'({zero_o, acc_o}));
  endtask

  task automatic t_ctrl();
    exec(LOAD_CTRL_PAGE_OP, 11'h005, 1);
    chk("acc", 16'h0035, 16'(acc_o));
    exec(LOAD_CTRL_PAGE_OP, 11'h00f, 1);
    chk("acc", 16'h003f, 16'(acc_o));
    chk("cp15", 16'h003f, 16'(meox_mem_model_inst.cp[15]));
    exec(STORE_CTRL_PAGE_OP, 11'h009, 1);
    chk("cp_wr", 16'h193f, 16'(cp_wr_o));
    // selector 4 lies below the page: no write, no load
    exec(STORE_CTRL_PAGE_OP, 11'h004, 1);
    chk("cp_we", 16'h0000, 16'(cp_wr_o.we));
    chk("cp9", 16'h003f, 16'(meox_mem_model_inst.cp[9]));
    exec(LOAD_CTRL_PAGE_OP, 11'h004, 1);
    chk("acc", 16'h003f, 16'(acc_o));
  endtask

  task automatic t_freg();
    exec(LOAD_CTRL_PAGE_OP, 11'h005, 1);
    z = zero_o;
    exec(OR_FILE_REG_OP, 11'h07f, 1);
    chk("acc", 16'h00b5, 16'(acc_o));
    chk("freg_we", 16'h0000, 16'(freg_wr_o.we));
    exec(OR_FILE_REG_OP, 11'h081, 1);
    chk("freg_wr", 16'h81ff, 16'(freg_wr_o));
    chk("acc", 16'h00b5, 16'(acc_o));
    exec(ACC_TO_FILE_REG_OP, 11'h040, 1);
    chk("freg_wr", 16'hc0b5, 16'(freg_wr_o));
    chk("zero", 16'(z), 16'(zero_o));
    chk("freg1", 16'h00ff, 16'(meox_mem_model_inst.freg[1]));
  endtask

  task automatic t_flow();
    exec(LONG_BRANCH_OP, 11'h7ff, 2);
    exec(LONG_CALL_OP, 11'h123, 2);
    exec(SOFT_IRQ_OP, 11'h000, 3);
    chk("gie", 16'h0000, 16'(gie_o));
    exec(RETURN_IRQ_ENABLE_OP, 11'h000, 2);
    chk("gie", 16'h0001, 16'(gie_o));
    // return address 0x7ff + 1 wraps to 0x000
    exec(RETURN_IRQ_ENABLE_OP, 11'h000, 2);
    // call then return at the first free edge: the pushed address comes straight back
    exec(LONG_CALL_OP, 11'h2a5, 2);
    exec(RETURN_IRQ_ENABLE_OP, 11'h000, 2);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1 rst_i = 1'b0;
    t_or_imm();
    t_ctrl();
    t_freg();
    t_flow();
    end_of_test();
  end
endmodule
